// >>> fbac_pkg.sv
// shared widths, encodings, reset values and carriers of the accumulator core
package fbac_pkg;

    // datapath and memory geometry
    localparam int ACC_W = 4;        // accumulator width
    localparam int ADDR_W = 4;       // memory address width
    localparam int WORD_W = 8;       // memory word width
    localparam int MEM_WORDS = 16;   // words of outside memory
    localparam int OPC_LSB = 4;      // opcode sits in the upper nibble
    localparam int OPND_LSB = 0;     // operand sits in the lower nibble

    // scan chain geometry
    localparam int SCAN_LEN = 19;    // bits of internal state shifted out
    localparam int SCAN_CNT_W = 5;   // width of the shift counter

    // reset values
    localparam logic [ADDR_W-1:0] PC_RST = 4'h0;
    localparam logic [ACC_W-1:0] ACC_RST = 4'h0;
    localparam logic [WORD_W-1:0] IR_RST = 8'h00;
    localparam logic [WORD_W-1:0] DOUT_RST = 8'h00;
    localparam logic [WORD_W-1:0] OE_B_RST = 8'hff;   // all data pins released
    localparam logic [SCAN_CNT_W-1:0] SCAN_LAST = 5'h12;  // index of first bit out
    localparam logic [SCAN_CNT_W-1:0] SCAN_CNT_RST = 5'h00;
    localparam logic [SCAN_LEN-1:0] SCAN_SH_RST = 19'h00000;
    localparam logic [ADDR_W-1:0] PC_STEP = 4'h1;
    localparam logic [ACC_W-1:0] ACC_ZERO = 4'h0;
    localparam logic [WORD_W-ACC_W-1:0] STORE_PAD = 4'h0;  // upper nibble of stored byte

    // operation codes
    typedef enum logic [3:0] {
        OP_NOP  = 4'h0,   // no effect, location may hold a variable
        OP_LDI  = 4'h1,   // acc = operand
        OP_LDA  = 4'h2,   // acc = mem[operand]
        OP_STA  = 4'h3,   // mem[operand] = acc
        OP_ADD  = 4'h4,   // acc = acc + mem[operand]
        OP_SUB  = 4'h5,   // acc = acc - mem[operand]
        OP_AND  = 4'h6,   // acc = acc & mem[operand]
        OP_OR   = 4'h7,   // acc = acc | mem[operand]
        OP_XOR  = 4'h8,   // acc = acc ^ mem[operand]
        OP_NOT  = 4'h9,   // acc = ~acc, operand ignored
        OP_JMP  = 4'ha,   // pc = operand
        OP_JZ   = 4'hb,   // pc = operand when zero flag set
        OP_JC   = 4'hc,   // pc = operand when carry flag set
        OP_ADDI = 4'hd,   // acc = acc + operand
        OP_SHR  = 4'he,   // acc = acc >> 1, operand ignored
        OP_NOP2 = 4'hf    // second no-operation code
    } fbac_op_t;

    // two halves of one outside cycle
    typedef enum logic {
        PH_FETCH,         // cycle clock low, instruction address presented
        PH_EXEC           // cycle clock high, operand address presented for memory operations, next address otherwise
    } fbac_phase_t;

    // all pins that arrive from the outside controller
    typedef struct packed {
        logic usr_clk;
        logic usr_rst;
        logic scan_clk;
        logic scan_en;
        logic mem_grant;
        logic [WORD_W-1:0] data;
    } fbac_pins_t;

    // visible processor state, exactly the scanned bits
    typedef struct packed {
        fbac_phase_t phase;
        logic carry;
        logic zero;
        logic [WORD_W-1:0] ir;
        logic [ACC_W-1:0] acc;
        logic [ADDR_W-1:0] pc;
    } fbac_cpu_t;

endpackage

// >>> fbac_scan.sv
`timescale 1ns/1ps
// serial debug shifter: loads a snapshot on a marked scan edge, then shifts
module fbac_scan (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic scan_rise,
    input wire logic scan_start,
    input wire logic [fbac_pkg::SCAN_LEN-1:0] snapshot,
    output logic scan_out
);

    // whole state of the shifter
    typedef struct packed {
        logic [fbac_pkg::SCAN_LEN-1:0] sh;     // bits still to go out, msb next
        logic [fbac_pkg::SCAN_CNT_W-1:0] left; // bits still held in sh
        logic out;                             // serial output flop
    } fbac_scan_st_t;

    fbac_scan_st_t st_reg;
    fbac_scan_st_t st_next;

    // next state: start, shift or hold
    always_comb begin
        st_next = st_reg;
        if (scan_rise) begin
            if (scan_start) begin
                // marked edge snapshots the state and shows its top bit
                st_next.out = snapshot[fbac_pkg::SCAN_LEN-1];
                st_next.sh = {snapshot[fbac_pkg::SCAN_LEN-2:0], 1'b0};
                st_next.left = fbac_pkg::SCAN_LAST;
            end else if (st_reg.left != fbac_pkg::SCAN_CNT_RST) begin
                // each later edge presents the next bit
                st_next.out = st_reg.sh[fbac_pkg::SCAN_LEN-1];
                st_next.sh = {st_reg.sh[fbac_pkg::SCAN_LEN-2:0], 1'b0};
                st_next.left = st_reg.left - 5'h01;
            end else begin
                // chain exhausted, output rests low
                st_next.out = 1'b0;
            end
        end
    end

    // register the state, frozen while the enable is low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg.sh <= fbac_pkg::SCAN_SH_RST;
            st_reg.left <= fbac_pkg::SCAN_CNT_RST;
            st_reg.out <= 1'b0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign scan_out = st_reg.out;

endmodule

// >>> fbac_core.sv
`timescale 1ns/1ps
// Operation
// - single four bit accumulator holds results
// - sixteen eight bit words hold code, data
// - upper nibble opcode, lower nibble operand
// - no-operation codes execute harmlessly as variables
// - fetch while cycle clock low, address presented
// - execution begins on cycle clock rising edge
// - store raises write request output
// - grant lets device drive store data
// - nineteen state bits scan out serially
// - scanning works in either cycle half
// - scan enable at rising edge starts scan
module fbac_core (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic usr_clk,
    input wire logic usr_rst,
    input wire logic scan_clk,
    input wire logic scan_en,
    input wire logic mem_grant,
    input wire logic [fbac_pkg::WORD_W-1:0] data_in,
    output logic [fbac_pkg::WORD_W-1:0] data_out,
    output logic [fbac_pkg::WORD_W-1:0] data_oe_b,
    output logic [fbac_pkg::ADDR_W-1:0] addr,
    output logic we,
    output logic scan_out
);

    // whole state of the core
    typedef struct packed {
        fbac_pkg::fbac_pins_t sync1;    // first synchroniser stage
        fbac_pkg::fbac_pins_t sync2;    // second synchroniser stage
        logic usr_clk_prev;             // cycle clock one sample ago
        logic scan_clk_prev;            // scan clock one sample ago
        fbac_pkg::fbac_cpu_t cpu;       // processor state
        logic [fbac_pkg::ADDR_W-1:0] addr;       // memory address pins
        logic we;                                // write request pin
        logic [fbac_pkg::WORD_W-1:0] dout;       // data pins when driven
        logic [fbac_pkg::WORD_W-1:0] oe_b;       // per-pin drive, low drives
    } fbac_core_st_t;

    fbac_core_st_t st_reg;
    fbac_core_st_t st_next;

    // pins gathered into one carrier for the synchroniser
    fbac_pkg::fbac_pins_t pins_raw;

    // synchronised views, all from the second stage
    logic usr_clk_s;
    logic usr_rst_s;
    logic scan_clk_s;
    logic grant_s;
    logic [fbac_pkg::WORD_W-1:0] data_s;
    logic usr_rise;                 // cycle clock rising edge seen
    logic usr_fall;                 // cycle clock falling edge seen
    logic scan_rise;                // scan clock rising edge seen

    // decoded instruction fields
    fbac_pkg::fbac_op_t opc;
    logic [fbac_pkg::ACC_W-1:0] opnd;
    fbac_pkg::fbac_op_t opc_new;    // opcode of the word being fetched
    logic needs_read_new;           // fetched word reads memory in its exec half
    logic needs_mem_new;            // fetched word touches memory at all
    logic needs_read;               // held word reads memory
    logic is_store;                 // held word writes memory

    // alu scratch, one bit wider for the carry
    logic [fbac_pkg::ACC_W:0] sum;
    logic [fbac_pkg::ACC_W-1:0] acc_new;
    logic carry_new;
    logic acc_wr;

    // snapshot fed to the scan chain
    logic [fbac_pkg::SCAN_LEN-1:0] snapshot;

    // bundle the asynchronous pins; nothing reads them before two flops
    always_comb begin
        pins_raw.usr_clk = usr_clk;
        pins_raw.usr_rst = usr_rst;
        pins_raw.scan_clk = scan_clk;
        pins_raw.scan_en = scan_en;
        pins_raw.mem_grant = mem_grant;
        pins_raw.data = data_in;
    end

    // synchronised signals and edge detection on the second stage only
    always_comb begin
        usr_clk_s = st_reg.sync2.usr_clk;
        usr_rst_s = st_reg.sync2.usr_rst;
        scan_clk_s = st_reg.sync2.scan_clk;
        grant_s = st_reg.sync2.mem_grant;
        data_s = st_reg.sync2.data;
        usr_rise = usr_clk_s && !st_reg.usr_clk_prev;
        usr_fall = !usr_clk_s && st_reg.usr_clk_prev;
        scan_rise = scan_clk_s && !st_reg.scan_clk_prev;
    end

    // instruction decode of the held word and of the word on the pins
    always_comb begin
        opc = fbac_pkg::fbac_op_t'(st_reg.cpu.ir[fbac_pkg::WORD_W-1:fbac_pkg::OPC_LSB]);
        opnd = st_reg.cpu.ir[fbac_pkg::OPC_LSB-1:fbac_pkg::OPND_LSB];
        opc_new = fbac_pkg::fbac_op_t'(data_s[fbac_pkg::WORD_W-1:fbac_pkg::OPC_LSB]);
        needs_read = 1'b0;
        needs_read_new = 1'b0;
        case (opc)
            fbac_pkg::OP_LDA, fbac_pkg::OP_ADD, fbac_pkg::OP_SUB,
            fbac_pkg::OP_AND, fbac_pkg::OP_OR, fbac_pkg::OP_XOR: begin
                needs_read = 1'b1;
            end
            default: begin
                needs_read = 1'b0;
            end
        endcase
        case (opc_new)
            fbac_pkg::OP_LDA, fbac_pkg::OP_ADD, fbac_pkg::OP_SUB,
            fbac_pkg::OP_AND, fbac_pkg::OP_OR, fbac_pkg::OP_XOR: begin
                needs_read_new = 1'b1;
            end
            default: begin
                needs_read_new = 1'b0;
            end
        endcase
        is_store = (opc == fbac_pkg::OP_STA);
        needs_mem_new = needs_read_new || (opc_new == fbac_pkg::OP_STA);
    end

    // alu: memory operands come from the data pins, others from the held word
    always_comb begin
        sum = {1'b0, st_reg.cpu.acc};
        acc_new = st_reg.cpu.acc;
        carry_new = st_reg.cpu.carry;
        acc_wr = 1'b0;
        case (opc)
            fbac_pkg::OP_LDI: begin
                acc_new = opnd;
                acc_wr = 1'b1;
            end
            fbac_pkg::OP_LDA: begin
                acc_new = data_s[fbac_pkg::ACC_W-1:0];
                acc_wr = 1'b1;
            end
            fbac_pkg::OP_ADD: begin
                // four bit result, the fifth bit becomes the carry
                sum = {1'b0, st_reg.cpu.acc} + {1'b0, data_s[fbac_pkg::ACC_W-1:0]};
                acc_new = sum[fbac_pkg::ACC_W-1:0];
                carry_new = sum[fbac_pkg::ACC_W];
                acc_wr = 1'b1;
            end
            fbac_pkg::OP_SUB: begin
                // carry set means a borrow occurred
                sum = {1'b0, st_reg.cpu.acc} - {1'b0, data_s[fbac_pkg::ACC_W-1:0]};
                acc_new = sum[fbac_pkg::ACC_W-1:0];
                carry_new = sum[fbac_pkg::ACC_W];
                acc_wr = 1'b1;
            end
            fbac_pkg::OP_AND: begin
                acc_new = st_reg.cpu.acc & data_s[fbac_pkg::ACC_W-1:0];
                acc_wr = 1'b1;
            end
            fbac_pkg::OP_OR: begin
                acc_new = st_reg.cpu.acc | data_s[fbac_pkg::ACC_W-1:0];
                acc_wr = 1'b1;
            end
            fbac_pkg::OP_XOR: begin
                acc_new = st_reg.cpu.acc ^ data_s[fbac_pkg::ACC_W-1:0];
                acc_wr = 1'b1;
            end
            fbac_pkg::OP_NOT: begin
                acc_new = ~st_reg.cpu.acc;
                acc_wr = 1'b1;
            end
            fbac_pkg::OP_ADDI: begin
                sum = {1'b0, st_reg.cpu.acc} + {1'b0, opnd};
                acc_new = sum[fbac_pkg::ACC_W-1:0];
                carry_new = sum[fbac_pkg::ACC_W];
                acc_wr = 1'b1;
            end
            fbac_pkg::OP_SHR: begin
                // low bit falls into the carry
                acc_new = {1'b0, st_reg.cpu.acc[fbac_pkg::ACC_W-1:1]};
                carry_new = st_reg.cpu.acc[0];
                acc_wr = 1'b1;
            end
            default: begin
                // nop, store and jumps leave the accumulator alone
                acc_wr = 1'b0;
            end
        endcase
    end

    // main sequencer: fetch half, execute half, store handshake
    always_comb begin
        st_next = st_reg;
        // two flop synchroniser, first stage read only by the second
        st_next.sync1 = pins_raw;
        st_next.sync2 = st_reg.sync1;
        st_next.usr_clk_prev = usr_clk_s;
        st_next.scan_clk_prev = scan_clk_s;

        if (usr_rst_s) begin
            // user reset holds the processor at address zero, edges ignored
            st_next.cpu.phase = fbac_pkg::PH_FETCH;
            st_next.cpu.pc = fbac_pkg::PC_RST;
            st_next.cpu.acc = fbac_pkg::ACC_RST;
            st_next.cpu.ir = fbac_pkg::IR_RST;
            st_next.cpu.zero = 1'b0;
            st_next.cpu.carry = 1'b0;
            st_next.addr = fbac_pkg::PC_RST;
            st_next.we = 1'b0;
        end else begin
            case (st_reg.cpu.phase)
                fbac_pkg::PH_FETCH: begin
                    // cycle clock low: program counter on the address pins
                    st_next.addr = st_reg.cpu.pc;
                    st_next.we = 1'b0;
                    if (usr_rise) begin
                        // latch the fetched word and begin execution
                        st_next.cpu.ir = data_s;
                        st_next.cpu.phase = fbac_pkg::PH_EXEC;
                        st_next.cpu.pc = st_reg.cpu.pc + fbac_pkg::PC_STEP;
                        // memory operations point at their operand word
                        if (needs_mem_new) begin
                            st_next.addr = data_s[fbac_pkg::OPC_LSB-1:fbac_pkg::OPND_LSB];
                        end else begin
                            st_next.addr = st_reg.cpu.pc + fbac_pkg::PC_STEP;
                        end
                        // a store marks the whole high half as a write
                        st_next.we = (opc_new == fbac_pkg::OP_STA);
                    end
                end
                fbac_pkg::PH_EXEC: begin
                    if (usr_fall) begin
                        // retire: results settle, next fetch begins
                        st_next.cpu.phase = fbac_pkg::PH_FETCH;
                        st_next.we = 1'b0;
                        if (acc_wr) begin
                            st_next.cpu.acc = acc_new;
                            st_next.cpu.carry = carry_new;
                            st_next.cpu.zero = (acc_new == fbac_pkg::ACC_ZERO);
                        end
                        // jumps replace the incremented program counter
                        if ((opc == fbac_pkg::OP_JMP)
                            || (opc == fbac_pkg::OP_JZ && st_reg.cpu.zero)
                            || (opc == fbac_pkg::OP_JC && st_reg.cpu.carry)) begin
                            st_next.cpu.pc = opnd;
                            st_next.addr = opnd;
                        end else begin
                            st_next.addr = st_reg.cpu.pc;
                        end
                    end
                end
                default: begin
                    st_next.cpu.phase = fbac_pkg::PH_FETCH;
                end
            endcase
        end

        // data pins driven only for a granted store in the execute half
        if (!usr_rst_s && st_reg.cpu.phase == fbac_pkg::PH_EXEC && is_store
            && st_reg.we && grant_s && !usr_fall) begin
            st_next.dout = {fbac_pkg::STORE_PAD, st_reg.cpu.acc};
            st_next.oe_b = {fbac_pkg::WORD_W{1'b0}};
        end else begin
            st_next.dout = fbac_pkg::DOUT_RST;
            st_next.oe_b = fbac_pkg::OE_B_RST;
        end
        // needs_read drops any write request standing under a word that reads memory
        if (needs_read && st_reg.we) begin
            st_next.we = 1'b0;
        end
    end

    // register all state, frozen while the clock enable is low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg.sync1 <= '0;
            st_reg.sync2 <= '0;
            st_reg.usr_clk_prev <= 1'b0;
            st_reg.scan_clk_prev <= 1'b0;
            st_reg.cpu.phase <= fbac_pkg::PH_FETCH;
            st_reg.cpu.carry <= 1'b0;
            st_reg.cpu.zero <= 1'b0;
            st_reg.cpu.ir <= fbac_pkg::IR_RST;
            st_reg.cpu.acc <= fbac_pkg::ACC_RST;
            st_reg.cpu.pc <= fbac_pkg::PC_RST;
            st_reg.addr <= fbac_pkg::PC_RST;
            st_reg.we <= 1'b0;
            st_reg.dout <= fbac_pkg::DOUT_RST;
            st_reg.oe_b <= fbac_pkg::OE_B_RST;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // snapshot is the live state, so a scan may start in either half
    assign snapshot = st_reg.cpu;

    // serial debug chain on its own outside clock
    fbac_scan u_scan (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .scan_rise(scan_rise),
        .scan_start(st_reg.sync2.scan_en),
        .snapshot(snapshot),
        .scan_out(scan_out)
    );

    // pin outputs straight from flops
    assign addr = st_reg.addr;
    assign we = st_reg.we;
    assign data_out = st_reg.dout;
    assign data_oe_b = st_reg.oe_b;

endmodule

// >>> fbac_core_assertions.sv
`timescale 1ns/1ps
// pin-level checks of the core, all on the system clock
module fbac_core_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic usr_clk,
    input wire logic usr_rst,
    input wire logic scan_clk,
    input wire logic scan_en,
    input wire logic mem_grant,
    input wire logic [fbac_pkg::WORD_W-1:0] data_in,
    input wire logic [fbac_pkg::WORD_W-1:0] data_out,
    input wire logic [fbac_pkg::WORD_W-1:0] data_oe_b,
    input wire logic [fbac_pkg::ADDR_W-1:0] addr,
    input wire logic we,
    input wire logic scan_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // pins driven only around a store
    oe_in_store_a: assert property (data_oe_b != 8'hff |-> we || $past(we))
        else $error("data pins driven outside a store");
    // whole bus driven or whole bus released
    oe_whole_bus_a: assert property (data_oe_b == 8'h00 || data_oe_b == 8'hff)
        else $error("data pins partly driven");
    // released pins carry no stale byte
    idle_data_a: assert property (data_oe_b == 8'hff |-> data_out == 8'h00)
        else $error("data output not cleared when released");
    // stored byte is the four bit accumulator, upper nibble clear
    store_pad_a: assert property (data_oe_b == 8'h00 |-> data_out[7:4] == 4'h0)
        else $error("stored byte upper nibble not clear");
    // quiet pins right after system reset
    reset_quiet_a: assert property ($rose(rst_b) |-> addr == 4'h0 && !we
        && data_oe_b == 8'hff)
        else $error("outputs not idle after reset");
    // user reset holds address and request low
    user_reset_a: assert property ((usr_rst && clk_en) [*8] |-> addr == 4'h0 && !we)
        else $error("user reset did not hold the core");
    // a write request only follows a cycle clock rise
    we_after_rise_a: assert property ($rose(we) |-> usr_clk && $past(usr_clk, 2))
        else $error("write request without cycle clock rise");
    // request and operand address hold while the store runs
    we_holds_a: assert property ($rose(we) |=> (we && $stable(addr)) [*4])
        else $error("write request or address unstable");
    // falling cycle clock ends the store
    fall_ends_a: assert property ($fell(usr_clk) |-> ##[1:6] (!we
        && data_oe_b == 8'hff))
        else $error("store not ended after cycle clock fall");
    cover property ($rose(we));
    cover property (data_oe_b == 8'h00);
    cover property ($rose(scan_out));
endmodule

bind fbac_core fbac_core_checker u_chk (.clk, .rst_b, .clk_en, .usr_clk, .usr_rst, .scan_clk,
    .scan_en, .mem_grant, .data_in, .data_out, .data_oe_b, .addr, .we, .scan_out);

// >>> fbac_mem_model.sv
`timescale 1ns/1ps
// outside controller memory: answers fetches, grants and captures stores
module fbac_mem_model (
    input wire logic clk,
    input wire logic [fbac_pkg::ADDR_W-1:0] addr,
    input wire logic we,
    input wire logic [fbac_pkg::WORD_W-1:0] data_out,
    input wire logic [fbac_pkg::WORD_W-1:0] data_oe_b,
    output logic mem_grant,
    output logic [fbac_pkg::WORD_W-1:0] data_in
);
    // code and data words
    logic [fbac_pkg::WORD_W-1:0] mem [fbac_pkg::MEM_WORDS];
    initial mem_grant = 1'b0;
    // grant follows the request; capture the byte once the core drives
    always @(posedge clk) begin
        mem_grant <= we;
        if (mem_grant && data_oe_b == 8'h00) begin
            mem[addr] <= data_out;
        end
    end
    // pin level: core bits where enabled, addressed word elsewhere
    assign data_in = (data_out & ~data_oe_b) | (mem[addr] & data_oe_b);
endmodule

// >>> fbac_core_tb_top.sv
`timescale 1ns/1ps
// steps programs through the core and reads its scan chain
module fbac_core_tb_top;
    // cycle clock half period, slow against clk
    localparam int HALF = 16;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic usr_clk = 1'b0;
    logic usr_rst = 1'b1;
    logic scan_clk = 1'b0;
    logic scan_en = 1'b0;
    logic mem_grant;
    logic [7:0] data_in, data_out, data_oe_b;
    logic [3:0] addr;
    logic we, scan_out;
    logic [18:0] got;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    fbac_core dut (.clk, .rst_b, .clk_en, .usr_clk, .usr_rst, .scan_clk, .scan_en, .mem_grant,
        .data_in, .data_out, .data_oe_b, .addr, .we, .scan_out);
    fbac_mem_model mem_model (.clk, .addr, .we, .data_out, .data_oe_b, .mem_grant, .data_in);

    // verdict and end of run
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            wrap_up;
        end
    end

    // compare and count
    task automatic chk(input logic [18:0] g, input logic [18:0] e, input string what);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one half period of the cycle clock
    task automatic half(input logic lvl);
        usr_clk <= lvl;
        tick(HALF);
    endtask

    // whole instruction cycles
    task automatic step(input int n);
        repeat (n) begin
            half(1'b1);
            half(1'b0);
        end
    endtask

    // marked start edge, then one bit per later scan edge, first bit first
    task automatic scan(output logic [18:0] v);
        scan_en <= 1'b1;
        tick(4);
        scan_clk <= 1'b1;
        tick(10);
        scan_en <= 1'b0;
        scan_clk <= 1'b0;
        for (int i = 18; i >= 0; i--) begin
            tick(10);
            v[i] = scan_out;
            if (i > 0) begin
                scan_clk <= 1'b1;
                tick(10);
                scan_clk <= 1'b0;
            end
        end
    endtask

    // user reset sequence leaves the pins idle
    task automatic t_reset;
        usr_rst <= 1'b1;
        tick(8);
        usr_clk <= 1'b1;
        tick(8);
        usr_clk <= 1'b0;
        tick(8);
        usr_rst <= 1'b0;
        tick(8);
        chk({6'h00, addr, we, data_oe_b},
            {6'h00, 4'h0, 1'b0, 8'hff}, "idle pins");
        $display("test reset done");
    endtask

    // load, add from memory, store the sum through the granted write
    task automatic t_store;
        step(2);
        usr_clk <= 1'b1;
        tick(8);
        chk({14'h0, addr, we}, {14'h0, 4'hf, 1'b1}, "store request");
        tick(8);
        half(1'b0);
        chk({11'h0, mem_model.mem[15]}, {11'h0, 8'h08}, "stored sum");
        $display("test store done");
    endtask

    // scan in the fetch half, then again in the execute half
    task automatic t_scan;
        step(1);
        scan(got);
        chk(got, {3'b000, 8'h19, 4'h9, 4'h4}, "scan fetch half");
        usr_clk <= 1'b1;
        tick(8);
        scan(got);
        chk(got, {3'b100, 8'h00, 4'h9, 4'h5}, "scan execute half");
        half(1'b0);
        $display("test scan done");
    endtask

    // a word with operand but no-operand code leaves the accumulator alone
    task automatic t_nop;
        step(2);
        chk({11'h0, mem_model.mem[13]}, {11'h0, 8'h09}, "acc after nop");
        chk({11'h0, mem_model.mem[5]}, {11'h0, 8'h07}, "variable word");
        $display("test nop done");
    endtask

    // accumulator wraps at four bits
    task automatic t_wrap;
        step(3);
        chk({11'h0, mem_model.mem[12]}, {11'h0, 8'h00}, "wrapped sum");
        $display("test wrap done");
    endtask

    // user reset mid-run, then load, subtract with borrow, logic ops, shift and jumps
    task automatic t_alu;
        mem_model.mem <= '{8'h2e, 8'h5f, 8'hc5, 8'h10, 8'hba, 8'h6e, 8'h7f, 8'h8e,
            8'h90, 8'he0, 8'h3d, 8'hb0, 8'ha3, 8'h00, 8'hf3, 8'h05};
        t_reset;
        step(9);
        chk({11'h0, mem_model.mem[13]}, {11'h0, 8'h05}, "logic chain");
        step(5);
        chk({11'h0, mem_model.mem[13]}, {11'h0, 8'h00}, "jump chain");
        $display("test alu done");
    endtask

    initial begin
        mem_model.mem = '{8'h15, 8'h4e, 8'h3f, 8'h19, 8'h00, 8'h07, 8'h3d, 8'h1f,
            8'hd1, 8'h3c, 8'h00, 8'h00, 8'hee, 8'hee, 8'h03, 8'hee};
        tick(16);
        rst_b <= 1'b1;
        tick(4);
        t_reset;
        t_store;
        t_scan;
        t_nop;
        t_wrap;
        t_alu;
        wrap_up;
    end
endmodule
